/* logic/cvn_pkg.sv */
package cvn_pkg;
	localparam int CLK_HZ        = 40000000;
	localparam int FILT_MS       = 2;
	localparam int FILT_CYCLES   = FILT_MS * (CLK_HZ / 1000);
	localparam int BLINK_MS      = 200;
	localparam int BLINK_CYCLES  = BLINK_MS * (CLK_HZ / 1000);

	localparam logic [10:0] ID_NMT  = 11'h000;
	localparam logic [10:0] ID_BOOT = 11'h700;
	localparam logic [10:0] ID_TPDO = 11'h180;
	localparam logic [10:0] ID_RPDO = 11'h200;
	localparam logic [3:0]  LEN_NMT  = 4'h2;
	localparam logic [3:0]  LEN_BOOT = 4'h1;
	localparam logic [3:0]  LEN_TPDO = 4'h4;
	localparam logic [3:0]  LEN_RPDO = 4'h3;
	localparam logic [7:0]  NMT_START = 8'h01;
	localparam logic [7:0]  NMT_STOP  = 8'h80;
	localparam logic [7:0]  NMT_RESET = 8'h81;
	localparam logic [7:0]  BOOT_DATA = 8'h00;

	localparam logic [15:0] OBJ_FILT  = 16'h6003;
	localparam logic [15:0] OBJ_PACK  = 16'h601F;
	localparam logic [15:0] OBJ_OUT   = 16'h6200;
	localparam logic [15:0] OBJ_FMODE = 16'h6206;
	localparam logic [15:0] OBJ_FVAL  = 16'h6207;
	localparam logic [7:0]  OUT_GROUPS = 8'h03;

	localparam logic [7:0]  FILT_RST       = 8'h01;
	localparam logic [7:0]  PACK_RST_NOEXT = 8'h00;
	localparam logic [7:0]  PACK_RST_EXT   = 8'h01;
	localparam logic [7:0]  PACK_NORMAL    = 8'h00;
	localparam logic [7:0]  PACK_SHIFT     = 8'h01;
	localparam logic [7:0]  PACK_HALF      = 8'h02;
	localparam logic [23:0] OUT_RST        = 24'h000000;

	localparam logic [7:0] WB_CTRL  = 8'h00;
	localparam logic [7:0] WB_NODE  = 8'h04;
	localparam logic [7:0] WB_OUTS  = 8'h08;
	localparam logic [7:0] WB_INIMG = 8'h0C;
	localparam logic [7:0] WB_STAT  = 8'h10;
	localparam logic [7:0] WB_CFGA  = 8'h14;
	localparam logic [7:0] WB_CFGD  = 8'h18;

	typedef enum {NMT_INIT, NMT_PREOP, NMT_OPER} cvn_nmt_t;
endpackage

/* logic/cvn_link_if.sv */
`timescale 1ns/1ps
interface cvn_link_if;
	logic        link_ok;
	logic        m_valid;
	logic [10:0] m_id;
	logic [3:0]  m_len;
	logic [63:0] m_data;
	logic        d_valid;
	logic        d_ready;
	logic [10:0] d_id;
	logic [3:0]  d_len;
	logic [63:0] d_data;
	logic        cfg_req;
	logic        cfg_we;
	logic [15:0] cfg_idx;
	logic [7:0]  cfg_sub;
	logic [7:0]  cfg_wdata;
	logic        cfg_ack;
	logic [7:0]  cfg_rdata;

	modport dev (input link_ok, m_valid, m_id, m_len, m_data, d_ready,
		cfg_req, cfg_we, cfg_idx, cfg_sub, cfg_wdata,
		output d_valid, d_id, d_len, d_data, cfg_ack, cfg_rdata);
	modport mst (output link_ok, m_valid, m_id, m_len, m_data, d_ready,
		cfg_req, cfg_we, cfg_idx, cfg_sub, cfg_wdata,
		input d_valid, d_id, d_len, d_data, cfg_ack, cfg_rdata);
endinterface

/* logic/cvn_glitch_filter.sv */
`timescale 1ns/1ps
module cvn_glitch_filter #(
	parameter int WIDTH  = 32,
	parameter int CYCLES = 80000
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             en_i,
	input  wire logic [WIDTH-1:0] raw_i,
	output logic      [WIDTH-1:0] level_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt [WIDTH];

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < WIDTH; i++) begin
			if (rst_i) begin
				cnt[i]     <= '0;
				level_o[i] <= 1'b0;
			end else if (!en_i) begin
				cnt[i]     <= '0;
				level_o[i] <= raw_i[i];
			end else if (raw_i[i] == level_o[i]) begin
				// Short pulse restarts the window
				cnt[i] <= '0;
			end else if (cnt[i] == LAST) begin
				cnt[i]     <= '0;
				level_o[i] <= raw_i[i];
			end else begin
				cnt[i] <= cnt[i] + 1'b1;
			end
		end
	end
endmodule

/* logic/cvn_node_dev.sv */
`timescale 1ns/1ps
module cvn_node_dev #(
	parameter int FILT_CYCLES  = cvn_pkg::FILT_CYCLES,
	parameter int BLINK_CYCLES = cvn_pkg::BLINK_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] din_i,
	input  wire logic [6:0]  node_addr_i,
	input  wire logic        ext_fitted_i,
	cvn_link_if.dev          lnk,
	output logic      [23:0] valve_o,
	output logic             bus_led_o
);
	localparam int BW = $clog2(BLINK_CYCLES + 1);
	localparam logic [BW-1:0] BLAST = BW'(BLINK_CYCLES - 1);

	logic [31:0]      din_s1, din_s2, din_f, image, last_img;
	logic [6:0]       addr_s1, addr_s2;
	logic             ext_s1, ext_s2, strap_done;
	logic [7:0]       filt_en, pack_mode;
	logic [23:0]      out_st, fmode, fval;
	cvn_pkg::cvn_nmt_t state;
	logic             boot_pend, in_pend, load_boot, load_tpdo;
	logic             nmt_hit, rpdo_hit, fault, cfg_wr;
	logic [7:0]       nmt_cmd;
	logic [BW-1:0]    blink_cnt;
	logic             blink;

	function automatic logic [31:0] pack_img(logic [31:0] d, logic [7:0] mode);
		logic [31:0] r;
		r = '0;
		case (mode)
			cvn_pkg::PACK_SHIFT: begin
				for (int k = 0; k < 32; k++) begin
					r[(k / 16) * 16 + (k % 2) * 8 + (k % 16) / 2] = d[k];
				end
			end
			cvn_pkg::PACK_HALF: begin
				for (int j = 0; j < 16; j++) begin
					r[j] = d[2 * j];
				end
			end
			default: r = d;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] get_byte(logic [23:0] v, logic [7:0] sub);
		case (sub)
			8'h01:   get_byte = v[7:0];
			8'h02:   get_byte = v[15:8];
			8'h03:   get_byte = v[23:16];
			default: get_byte = cvn_pkg::OUT_GROUPS;
		endcase
	endfunction

	function automatic logic [23:0] put_byte(logic [23:0] v, logic [7:0] sub,
			logic [7:0] d);
		logic [23:0] r;
		r = v;
		case (sub)
			8'h01:   r[7:0] = d;
			8'h02:   r[15:8] = d;
			8'h03:   r[23:16] = d;
			default: r = v;
		endcase
		return r;
	endfunction

	// Pins come from outside; straps settle during reset
	always_ff @(posedge clk_i) begin
		din_s1  <= din_i;
		din_s2  <= din_s1;
		addr_s1 <= node_addr_i;
		addr_s2 <= addr_s1;
		ext_s1  <= ext_fitted_i;
		ext_s2  <= ext_s1;
	end

	cvn_glitch_filter #(
		.WIDTH  (32),
		.CYCLES (FILT_CYCLES)
	) u_filt (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.en_i    (filt_en != 8'h00),
		.raw_i   (din_s2),
		.level_o (din_f)
	);

	assign image = pack_img(din_f, pack_mode);

	assign nmt_cmd = lnk.m_data[7:0];
	assign nmt_hit = lnk.m_valid && lnk.m_id == cvn_pkg::ID_NMT
		&& lnk.m_len == cvn_pkg::LEN_NMT
		&& (lnk.m_data[15:8] == 8'h00 || lnk.m_data[15:8] == {1'b0, addr_s2});
	assign rpdo_hit = lnk.m_valid && state == cvn_pkg::NMT_OPER
		&& lnk.m_id == cvn_pkg::ID_RPDO + {4'h0, addr_s2}
		&& lnk.m_len == cvn_pkg::LEN_RPDO;
	// link loss is the fault condition
	assign fault  = !lnk.link_ok;
	assign cfg_wr = lnk.cfg_req && lnk.cfg_we;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= cvn_pkg::NMT_INIT;
		end else begin
			case (state)
				cvn_pkg::NMT_INIT: state <= cvn_pkg::NMT_PREOP;
				cvn_pkg::NMT_PREOP: begin
					if (nmt_hit && nmt_cmd == cvn_pkg::NMT_START) begin
						state <= cvn_pkg::NMT_OPER;
					end else if (nmt_hit && nmt_cmd == cvn_pkg::NMT_RESET) begin
						state <= cvn_pkg::NMT_INIT;
					end
				end
				cvn_pkg::NMT_OPER: begin
					if (nmt_hit && nmt_cmd == cvn_pkg::NMT_STOP) begin
						state <= cvn_pkg::NMT_PREOP;
					end else if (nmt_hit && nmt_cmd == cvn_pkg::NMT_RESET) begin
						state <= cvn_pkg::NMT_INIT;
					end
				end
				default: state <= cvn_pkg::NMT_INIT;
			endcase
		end
	end

	assign load_boot = !lnk.d_valid && boot_pend;
	assign load_tpdo = !lnk.d_valid && !boot_pend && in_pend
		&& state == cvn_pkg::NMT_OPER;

	// boot-up only from the init state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boot_pend <= 1'b0;
		end else if (state == cvn_pkg::NMT_INIT) begin
			boot_pend <= 1'b1;
		end else if (load_boot) begin
			boot_pend <= 1'b0;
		end
	end

	// Loaded copy is the reference, so no change goes unsent
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_pend <= 1'b0;
		end else if (state == cvn_pkg::NMT_PREOP && nmt_hit
				&& nmt_cmd == cvn_pkg::NMT_START) begin
			in_pend <= 1'b1;
		end else if (state != cvn_pkg::NMT_OPER || load_tpdo) begin
			in_pend <= 1'b0;
		end else if (image != last_img) begin
			in_pend <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk.d_valid <= 1'b0;
			lnk.d_id    <= '0;
			lnk.d_len   <= '0;
			lnk.d_data  <= '0;
			last_img    <= '0;
		end else if (lnk.d_valid) begin
			if (lnk.d_ready) begin
				lnk.d_valid <= 1'b0;
			end
		end else if (load_boot) begin
			lnk.d_valid <= 1'b1;
			lnk.d_id    <= cvn_pkg::ID_BOOT + {4'h0, addr_s2};
			lnk.d_len   <= cvn_pkg::LEN_BOOT;
			lnk.d_data  <= {56'h0, cvn_pkg::BOOT_DATA};
		end else if (load_tpdo) begin
			lnk.d_valid <= 1'b1;
			lnk.d_id    <= cvn_pkg::ID_TPDO + {4'h0, addr_s2};
			lnk.d_len   <= cvn_pkg::LEN_TPDO;
			lnk.d_data  <= {32'h0, image};
			last_img    <= image;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filt_en    <= cvn_pkg::FILT_RST;
			pack_mode  <= cvn_pkg::PACK_RST_NOEXT;
			strap_done <= 1'b0;
		end else begin
			strap_done <= 1'b1;
			if (!strap_done) begin
				pack_mode <= ext_s2 ? cvn_pkg::PACK_RST_EXT : cvn_pkg::PACK_RST_NOEXT;
			end else if (cfg_wr && lnk.cfg_idx == cvn_pkg::OBJ_PACK
					&& lnk.cfg_sub == 8'h00) begin
				pack_mode <= lnk.cfg_wdata;
			end
			if (cfg_wr && lnk.cfg_idx == cvn_pkg::OBJ_FILT && lnk.cfg_sub == 8'h00) begin
				filt_en <= lnk.cfg_wdata;
			end
		end
	end

	// output bytes from frame or config
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_st <= cvn_pkg::OUT_RST;
		end else if (rpdo_hit) begin
			out_st <= lnk.m_data[23:0];
		end else if (cfg_wr && lnk.cfg_idx == cvn_pkg::OBJ_OUT) begin
			out_st <= put_byte(out_st, lnk.cfg_sub, lnk.cfg_wdata);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fmode <= cvn_pkg::OUT_RST;
			fval  <= cvn_pkg::OUT_RST;
		end else if (cfg_wr && lnk.cfg_idx == cvn_pkg::OBJ_FMODE) begin
			fmode <= put_byte(fmode, lnk.cfg_sub, lnk.cfg_wdata);
		end else if (cfg_wr && lnk.cfg_idx == cvn_pkg::OBJ_FVAL) begin
			fval <= put_byte(fval, lnk.cfg_sub, lnk.cfg_wdata);
		end
	end

	// hold own state or force value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valve_o <= cvn_pkg::OUT_RST;
		end else if (fault) begin
			valve_o <= (fmode & valve_o) | (~fmode & fval);
		end else begin
			valve_o <= out_st;
		end
	end

	// entry count read at sub-index zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk.cfg_ack   <= 1'b0;
			lnk.cfg_rdata <= '0;
		end else begin
			lnk.cfg_ack <= lnk.cfg_req;
			if (lnk.cfg_req) begin
				case (lnk.cfg_idx)
					cvn_pkg::OBJ_FILT:  lnk.cfg_rdata <= filt_en;
					cvn_pkg::OBJ_PACK:  lnk.cfg_rdata <= pack_mode;
					cvn_pkg::OBJ_OUT:   lnk.cfg_rdata <= get_byte(out_st, lnk.cfg_sub);
					cvn_pkg::OBJ_FMODE: lnk.cfg_rdata <= get_byte(fmode, lnk.cfg_sub);
					cvn_pkg::OBJ_FVAL:  lnk.cfg_rdata <= get_byte(fval, lnk.cfg_sub);
					default:            lnk.cfg_rdata <= 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state != cvn_pkg::NMT_PREOP) begin
			blink_cnt <= '0;
			blink     <= 1'b1;
		end else if (blink_cnt == BLAST) begin
			blink_cnt <= '0;
			blink     <= !blink;
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_led_o <= 1'b0;
		end else begin
			bus_led_o <= (state == cvn_pkg::NMT_OPER)
				|| (state == cvn_pkg::NMT_PREOP && blink);
		end
	end
endmodule

/* logic/cvn_node_mst.sv */
`timescale 1ns/1ps
module cvn_node_mst (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        we_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	cvn_link_if.mst          lnk
);
	logic        req, wr, cfg_busy, boot_seen, in_seen;
	logic [6:0]  node, boot_node;
	logic [23:0] outs;
	logic [31:0] inimg, cfga, wv, outs_wv;

	function automatic logic [31:0] lanes(logic [31:0] old, logic [31:0] d,
			logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign req = cyc_i && stb_i && !ack_o;
	assign wr  = req && we_i;
	assign wv  = lanes(32'h0, dat_i, sel_i);
	// Merged word kept whole; only its low three bytes are stored
	assign outs_wv = lanes({8'h0, outs}, dat_i, sel_i);
	// Host never stalls the node's frames
	assign lnk.d_ready = 1'b1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk.link_ok <= 1'b0;
			node        <= '0;
			outs        <= '0;
			cfga        <= '0;
		end else if (wr) begin
			case (adr_i)
				cvn_pkg::WB_CTRL: lnk.link_ok <= sel_i[0] ? dat_i[4] : lnk.link_ok;
				cvn_pkg::WB_NODE: node <= sel_i[0] ? dat_i[6:0] : node;
				cvn_pkg::WB_OUTS: outs <= outs_wv[23:0];
				cvn_pkg::WB_CFGA: cfga <= lanes(cfga, dat_i, sel_i);
				default:          node <= node;
			endcase
		end
	end

	// One frame per control write with a bit of 3:0 set; reset beats stop beats start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk.m_valid <= 1'b0;
			lnk.m_id    <= '0;
			lnk.m_len   <= '0;
			lnk.m_data  <= '0;
		end else begin
			lnk.m_valid <= 1'b0;
			if (wr && adr_i == cvn_pkg::WB_CTRL && wv[3:0] != 4'h0) begin
				lnk.m_valid <= 1'b1;
				lnk.m_id    <= cvn_pkg::ID_NMT;
				lnk.m_len   <= cvn_pkg::LEN_NMT;
				if (wv[2]) begin
					lnk.m_data <= {48'h0, 1'b0, node, cvn_pkg::NMT_RESET};
				end else if (wv[1]) begin
					lnk.m_data <= {48'h0, 1'b0, node, cvn_pkg::NMT_STOP};
				end else if (wv[0]) begin
					lnk.m_data <= {48'h0, 1'b0, node, cvn_pkg::NMT_START};
				end else begin
					lnk.m_id   <= cvn_pkg::ID_RPDO + {4'h0, node};
					lnk.m_len  <= cvn_pkg::LEN_RPDO;
					lnk.m_data <= {40'h0, outs};
				end
			end
		end
	end

	// Hardware set wins over a software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boot_seen <= 1'b0;
			in_seen   <= 1'b0;
			boot_node <= '0;
			inimg     <= '0;
		end else begin
			if (wr && adr_i == cvn_pkg::WB_STAT) begin
				boot_seen <= boot_seen && !wv[0];
				in_seen   <= in_seen && !wv[1];
			end
			if (lnk.d_valid && lnk.d_id[10:7] == cvn_pkg::ID_BOOT[10:7]) begin
				boot_seen <= 1'b1;
				boot_node <= lnk.d_id[6:0];
			end
			if (lnk.d_valid && lnk.d_id[10:7] == cvn_pkg::ID_TPDO[10:7]) begin
				in_seen <= 1'b1;
				inimg   <= lnk.d_data[31:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk.cfg_req   <= 1'b0;
			lnk.cfg_we    <= 1'b0;
			lnk.cfg_idx   <= '0;
			lnk.cfg_sub   <= '0;
			lnk.cfg_wdata <= '0;
			cfg_busy      <= 1'b0;
		end else begin
			lnk.cfg_req <= 1'b0;
			if (req && adr_i == cvn_pkg::WB_CFGD && !cfg_busy) begin
				lnk.cfg_req   <= 1'b1;
				lnk.cfg_we    <= we_i && sel_i[0];
				lnk.cfg_idx   <= cfga[23:8];
				lnk.cfg_sub   <= cfga[7:0];
				lnk.cfg_wdata <= dat_i[7:0];
				cfg_busy      <= 1'b1;
			end else if (lnk.cfg_ack) begin
				cfg_busy <= 1'b0;
			end
		end
	end

	// Config access waits for the node; others answer next edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= (req && adr_i != cvn_pkg::WB_CFGD) || lnk.cfg_ack;
			if (lnk.cfg_ack) begin
				dat_o <= {24'h0, lnk.cfg_rdata};
			end else if (req) begin
				case (adr_i)
					cvn_pkg::WB_CTRL:  dat_o <= {27'h0, lnk.link_ok, 4'h0};
					cvn_pkg::WB_NODE:  dat_o <= {25'h0, node};
					cvn_pkg::WB_OUTS:  dat_o <= {8'h0, outs};
					cvn_pkg::WB_INIMG: dat_o <= inimg;
					cvn_pkg::WB_STAT:  dat_o <= {17'h0, boot_node, 6'h0, in_seen, boot_seen};
					cvn_pkg::WB_CFGA:  dat_o <= cfga;
					default:           dat_o <= 32'h0;
				endcase
			end
		end
	end
endmodule

/* sim/cvn_link_properties.sv */
`timescale 1ns/1ps
module cvn_link_properties #(
	parameter logic [6:0] NODE = 7'h05
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        m_valid,
	input wire logic [10:0] m_id,
	input wire logic [3:0]  m_len,
	input wire logic [63:0] m_data,
	input wire logic        d_valid,
	input wire logic [10:0] d_id,
	input wire logic [3:0]  d_len,
	input wire logic [63:0] d_data,
	input wire logic        cfg_req,
	input wire logic        cfg_we,
	input wire logic [15:0] cfg_idx,
	input wire logic [7:0]  cfg_sub,
	input wire logic        cfg_ack,
	input wire logic [7:0]  cfg_rdata
);
	logic nmt;
	logic oper;
	logic boot_v;
	logic in_v;
	// Own address or broadcast only
	assign nmt = m_valid && m_id == cvn_pkg::ID_NMT && m_len == cvn_pkg::LEN_NMT
		&& (m_data[15:8] == 8'h00 || m_data[15:8] == {1'b0, NODE});
	assign boot_v = d_valid && d_len == cvn_pkg::LEN_BOOT;
	assign in_v = d_valid && d_len == cvn_pkg::LEN_TPDO;
	// Shadow of the node state, so a repeated start is not expected to send
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oper <= 1'b0;
		end else if (nmt && m_data[7:0] == cvn_pkg::NMT_START) begin
			oper <= 1'b1;
		end else if (nmt && m_data[7:0] != cvn_pkg::NMT_START) begin
			oper <= 1'b0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_start;
		nmt && m_data[7:0] == cvn_pkg::NMT_START && !oper;
	endsequence
	sequence s_boot;
		boot_v;
	endsequence
	sequence s_input;
		in_v;
	endsequence
	property p_start_frame;
		s_start |-> ##[1:4] s_input;
	endproperty
	property p_in_id;
		s_input |-> d_id == cvn_pkg::ID_TPDO + {4'h0, NODE};
	endproperty
	property p_boot_id;
		s_boot |-> d_id == cvn_pkg::ID_BOOT + {4'h0, NODE} && d_data[7:0] == cvn_pkg::BOOT_DATA;
	endproperty
	property p_boot_once;
		s_boot |=> (!boot_v) [*8];
	endproperty
	property p_stop_quiet;
		nmt && m_data[7:0] == cvn_pkg::NMT_STOP |-> (!boot_v) [*8];
	endproperty
	property p_reset_boot;
		nmt && m_data[7:0] == cvn_pkg::NMT_RESET |-> ##[1:8] s_boot;
	endproperty
	property p_count_entry;
		cfg_req && !cfg_we && cfg_sub == 8'h00 && (cfg_idx == cvn_pkg::OBJ_OUT
			|| cfg_idx == cvn_pkg::OBJ_FMODE || cfg_idx == cvn_pkg::OBJ_FVAL)
			|=> cfg_ack && cfg_rdata == cvn_pkg::OUT_GROUPS;
	endproperty
	property p_ack_cause;
		cfg_ack |-> $past(cfg_req);
	endproperty
	a_start_frame: assert property (p_start_frame) else $error("no input frame");
	a_in_id: assert property (p_in_id) else $error("input frame id");
	a_boot_id: assert property (p_boot_id) else $error("boot frame");
	a_boot_once: assert property (p_boot_once) else $error("boot repeated");
	a_stop_quiet: assert property (p_stop_quiet) else $error("boot on stop");
	a_reset_boot: assert property (p_reset_boot) else $error("no boot");
	a_count_entry: assert property (p_count_entry) else $error("entry count");
	a_ack_cause: assert property (p_ack_cause) else $error("stray config ack");
endmodule

/* sim/cvn_node_tb.sv */
`timescale 1ns/1ps
module cvn_node_tb;
	localparam logic [6:0] NODE = 7'h05;
	logic        clk_i;
	logic        rst_i;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] din;
	logic [23:0] valve;
	logic        we;
	logic        stb;
	logic        ack;
	logic        led;
	logic        ext;
	logic [31:0] q;
	logic [1:0]  s;
	logic [31:0] pats [3] = '{32'h8000_0101, 32'hA5C3_0F12, 32'h5A3C_F0E1};
	logic [15:0] objs [3] = '{cvn_pkg::OBJ_OUT, cvn_pkg::OBJ_FMODE, cvn_pkg::OBJ_FVAL};
	int          miscompares;
	int          compares;
	cvn_link_if link ();
	cvn_node_dev #(.FILT_CYCLES(8), .BLINK_CYCLES(4)) cvn_node_dev_inst (.clk_i(clk_i),
		.rst_i(rst_i), .din_i(din), .node_addr_i(NODE), .ext_fitted_i(ext), .lnk(link.dev),
		.valve_o(valve), .bus_led_o(led));
	cvn_node_mst cvn_node_mst_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
		.sel_i(4'hF), .we_i(we), .cyc_i(stb), .stb_i(stb), .dat_o(rdat), .ack_o(ack),
		.lnk(link.mst));
	cvn_link_properties #(.NODE(NODE)) cvn_link_properties_inst (.clk_i(clk_i),
		.rst_i(rst_i), .m_valid(link.m_valid), .m_id(link.m_id), .m_len(link.m_len),
		.m_data(link.m_data), .d_valid(link.d_valid), .d_id(link.d_id), .d_len(link.d_len),
		.d_data(link.d_data), .cfg_req(link.cfg_req), .cfg_we(link.cfg_we),
		.cfg_idx(link.cfg_idx), .cfg_sub(link.cfg_sub), .cfg_ack(link.cfg_ack),
		.cfg_rdata(link.cfg_rdata));
	task automatic conclude();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		adr <= a;
		we <= w;
		wdat <= d;
		stb <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			miscompares++;
			conclude();
		end
		q = rdat;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic cfg(input logic [15:0] i, input logic [7:0] sub, input logic w,
		input logic [7:0] d);
		wb(cvn_pkg::WB_CFGA, 1'b1, {8'h00, i, sub});
		wb(cvn_pkg::WB_CFGD, w, {24'h0, d});
	endtask
	// Polls instead of counting cycles, the frame timing is not fixed
	task automatic wait_stat(input int b);
		int n;
		n = 0;
		do begin
			wb(cvn_pkg::WB_STAT, 1'b0, 32'h0);
			n++;
		end while (q[b] !== 1'b1 && n < 40);
		chk({31'h0, q[b]}, 32'h1);
	endtask
	task automatic led_seen();
		s = 2'b00;
		repeat (20) begin
			@(posedge clk_i);
			s = s | {led === 1'b1, led === 1'b0};
		end
	endtask
	function automatic logic [31:0] pack(input logic [7:0] m, input logic [31:0] v);
		logic [31:0] r;
		r = v;
		for (int k = 0; k < 32; k++) begin
			if (m == cvn_pkg::PACK_SHIFT) begin
				r[(k / 16) * 16 + (k % 2) * 8 + (k % 16) / 2] = v[k];
			end else if (m == cvn_pkg::PACK_HALF) begin
				r[k] = (k < 16) ? v[2 * k] : 1'b0;
			end
		end
		return r;
	endfunction
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		din = 32'h0;
		ext = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_stat(0);
		chk({25'h0, q[14:8]}, {25'h0, NODE});
		led_seen();
		chk({30'h0, s}, 32'h3);
		wb(cvn_pkg::WB_NODE, 1'b1, {25'h0, NODE});
		wb(cvn_pkg::WB_STAT, 1'b1, 32'h3);
		cfg(cvn_pkg::OBJ_FILT, 8'h00, 1'b0, 8'h00);
		chk(q, {24'h0, cvn_pkg::FILT_RST});
		cfg(cvn_pkg::OBJ_PACK, 8'h00, 1'b0, 8'h00);
		chk(q, {24'h0, cvn_pkg::PACK_RST_NOEXT});
		for (int i = 0; i < 3; i++) begin
			cfg(objs[i], 8'h00, 1'b1, 8'h7E);
			cfg(objs[i], 8'h00, 1'b0, 8'h00);
			chk(q, 32'h3);
		end
		cfg(16'h1234, 8'h00, 1'b0, 8'h00);
		chk(q, 32'h0);
		wb(8'h40, 1'b1, 32'hFFFF_FFFF);
		wb(8'h40, 1'b0, 32'h0);
		chk(q, 32'h0);
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h11);
		wait_stat(1);
		wb(cvn_pkg::WB_INIMG, 1'b0, 32'h0);
		chk(q, 32'h0);
		led_seen();
		chk({30'h0, s}, 32'h2);
		wb(cvn_pkg::WB_STAT, 1'b1, 32'h3);
		din <= 32'h8000_0000;
		repeat (5) @(posedge clk_i);
		din <= 32'h0;
		repeat (40) @(posedge clk_i);
		wb(cvn_pkg::WB_STAT, 1'b0, 32'h0);
		chk({31'h0, q[1]}, 32'h0);
		for (int i = 0; i < 3; i++) begin
			cfg(cvn_pkg::OBJ_PACK, 8'h00, 1'b1, 8'(i));
			wb(cvn_pkg::WB_STAT, 1'b1, 32'h3);
			din <= pats[i];
			wait_stat(1);
			repeat (30) @(posedge clk_i);
			wb(cvn_pkg::WB_INIMG, 1'b0, 32'h0);
			chk(q, pack(8'(i), pats[i]));
		end
		wb(cvn_pkg::WB_OUTS, 1'b1, 32'h003C_A55A);
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h18);
		repeat (4) @(posedge clk_i);
		chk({8'h0, valve}, 32'h003C_A55A);
		cfg(cvn_pkg::OBJ_FMODE, 8'h01, 1'b1, 8'hF0);
		cfg(cvn_pkg::OBJ_FVAL, 8'h01, 1'b1, 8'h55);
		cfg(cvn_pkg::OBJ_FVAL, 8'h03, 1'b1, 8'hFF);
		cfg(cvn_pkg::OBJ_FMODE, 8'h01, 1'b0, 8'h00);
		chk(q, 32'hF0);
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h0);
		repeat (4) @(posedge clk_i);
		chk({8'h0, valve}, {8'h0, (24'hF0 & 24'h3CA55A) | (~24'hF0 & 24'hFF0055)});
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h10);
		repeat (4) @(posedge clk_i);
		chk({8'h0, valve}, 32'h003C_A55A);
		wb(cvn_pkg::WB_NODE, 1'b1, 32'h09);
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h12);
		led_seen();
		chk({30'h0, s}, 32'h2);
		wb(cvn_pkg::WB_NODE, 1'b1, {25'h0, NODE});
		wb(cvn_pkg::WB_STAT, 1'b1, 32'h3);
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h12);
		led_seen();
		chk({30'h0, s}, 32'h3);
		wb(cvn_pkg::WB_STAT, 1'b0, 32'h0);
		chk({31'h0, q[0]}, 32'h0);
		wb(cvn_pkg::WB_OUTS, 1'b1, 32'h0000_00FF);
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h18);
		repeat (4) @(posedge clk_i);
		chk({8'h0, valve}, 32'h003C_A55A);
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h14);
		wait_stat(0);
		wb(cvn_pkg::WB_CTRL, 1'b1, 32'h11);
		wait_stat(1);
		// Second reset with the extension strap set
		ext <= 1'b1;
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_stat(0);
		chk({8'h0, valve}, {8'h0, cvn_pkg::OUT_RST});
		cfg(cvn_pkg::OBJ_PACK, 8'h00, 1'b0, 8'h00);
		chk(q, {24'h0, cvn_pkg::PACK_RST_EXT});
		cfg(cvn_pkg::OBJ_FILT, 8'h00, 1'b0, 8'h00);
		chk(q, {24'h0, cvn_pkg::FILT_RST});
		conclude();
	end
endmodule
